// [src/hw_pin_config_control.sv]
`timescale 1ns/10ps
// How it works
// - With negotiation on, a rising config input zero restarts it on every port and sets bit 0.9.
// - With negotiation off, config input zero high picks 100 Mbps (0.13 set), low picks 10 Mbps.
// - With negotiation on, config inputs one and two and the all-port duplex set the advertisement.
// - With negotiation off, config input one high disables the 10 Mbps link test (19.8 set).
// - With negotiation off, config input two low picks twisted pair, high picks fiber (19.2).
// - A fiber port always bypasses its scrambler whatever the bypass input says.
// - A high all-port duplex enable gives full duplex on all four ports.
// - A high fiber duplex enable gives full duplex on fiber ports only.
// - In twisted pair mode the bypass input high bypasses the scrambler and sets 19.3.
// - The negotiation enable input high turns negotiation on for all ports, low forces modes.
// - Management disable high keeps pins in control and writes refused, low loads at reset only.
module hw_pin_config_control (
  input logic CLK,
  input logic SRST,
  input logic CE,
  input logic [2:0] CONFIG_IN,
  input logic AUTONEG_ENABLE_IN,
  input logic MANAGEMENT_DISABLE_IN,
  input logic SCRAMBLER_BYPASS_IN,
  input logic ALL_PORT_DUPLEX_ENABLE,
  input logic FIBER_PORT_DUPLEX_ENABLE,
  input logic PSEL,
  input logic PENABLE,
  input logic PWRITE,
  input logic [hw_cfg_pkg::ADDR_W-1:0] PADDR,
  input logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic AUTONEG_ON,
  output logic SPEED_100,
  output logic LINK_TEST_OFF,
  output logic [3:0] ADVERTISE,
  output logic [hw_cfg_pkg::NUM_PORTS-1:0] AUTONEG_RESTART,
  output logic [hw_cfg_pkg::NUM_PORTS-1:0] FX_MODE,
  output logic [hw_cfg_pkg::NUM_PORTS-1:0] SCRAMBLER_OFF,
  output logic [hw_cfg_pkg::NUM_PORTS-1:0] FULL_DUPLEX
);
  import hw_cfg_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    mode_t mode;
    logic [1:0] load_cnt;
    logic cfg0_prev;
    logic an_en;
    logic speed;
    logic restart;
    logic duplex;
    logic fx_duplex;
    logic link_off;
    logic scr_byp;
    logic fx;
    logic [3:0] adv;
    logic [31:0] rdata;
    logic slverr;
  } ctl_state_t;

  ctl_state_t st;
  ctl_state_t next_st;

  logic [PIN_COUNT-1:0] raw_pins;
  logic [PIN_COUNT-1:0] s_pins;
  logic [2:0] cfg;
  logic an_p;
  logic md;
  logic scr_p;
  logic dup_all;
  logic dup_fx;
  logic run;
  logic restart_edge;
  logic setup;
  logic wr_acc;
  logic wr_ok;
  logic sw_restart;
  logic mapped;
  logic read_only;
  logic [31:0] rd;
  logic [NUM_PORTS-1:0] fx_w;
  logic [NUM_PORTS-1:0] scr_w;
  logic [NUM_PORTS-1:0] fd_w;

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  function automatic logic [3:0] advert(logic c1, logic c2, logic fd);
    logic a10;
    logic a100;
    a10 = !c1 | c2;
    a100 = c1 | c2;
    return {a100 & fd, a100, a10 & fd, a10};
  endfunction

  function automatic ctl_state_t apply_pins(ctl_state_t s, logic [2:0] c, logic an,
                                            logic fd, logic fdx, logic scr);
    ctl_state_t r;
    r = s;
    r.an_en = an;
    r.duplex = fd;
    r.fx_duplex = fdx;
    r.scr_byp = scr;
    if (an) begin
      r.adv = advert(c[1], c[2], fd);
    end else begin
      r.speed = c[0];
      r.link_off = c[1];
      r.fx = c[2];
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  assign raw_pins = {MANAGEMENT_DISABLE_IN, AUTONEG_ENABLE_IN, SCRAMBLER_BYPASS_IN,
                     ALL_PORT_DUPLEX_ENABLE, FIBER_PORT_DUPLEX_ENABLE, CONFIG_IN};

  pin_sync #(
    .W(PIN_COUNT)
  ) u_sync (
    .clk(CLK),
    .srst(SRST),
    .ce(CE),
    .d(raw_pins),
    .q(s_pins)
  );

  assign cfg = s_pins[2:0];
  assign dup_fx = s_pins[3];
  assign dup_all = s_pins[4];
  assign scr_p = s_pins[5];
  assign an_p = s_pins[6];
  assign md = s_pins[7];

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign run = (st.mode == MODE_RUN);
  assign restart_edge = run && st.an_en && cfg[0] && !st.cfg0_prev;
  assign setup = PSEL && !PENABLE;
  assign wr_acc = PSEL && PENABLE && PWRITE;
  assign wr_ok = wr_acc && !md && run;
  assign sw_restart = wr_ok && (PADDR == ADDR_CONTROL) && PWDATA[BIT_RESTART];
  assign mapped = (PADDR == ADDR_CONTROL) || (PADDR == ADDR_CONFIG) ||
                  (PADDR == ADDR_ADVERT) || (PADDR == ADDR_STATUS);
  assign read_only = (PADDR == ADDR_ADVERT) || (PADDR == ADDR_STATUS);

  always_comb begin
    rd = '0;
    case (PADDR)
      ADDR_CONTROL: begin
        rd[BIT_SPEED] = st.speed;
        rd[BIT_AN_EN] = st.an_en;
        rd[BIT_RESTART] = st.restart;
        rd[BIT_DUPLEX] = st.duplex;
      end
      ADDR_CONFIG: begin
        rd[BIT_LINK_OFF] = st.link_off;
        rd[BIT_SCR_BYP] = st.scr_byp;
        rd[BIT_FX] = st.fx;
        rd[BIT_FX_DUPLEX] = st.fx_duplex;
      end
      ADDR_ADVERT: begin
        rd[3:0] = st.adv;
      end
      ADDR_STATUS: begin
        rd[ST_MD] = md;
        rd[ST_LOADING] = !run;
        rd[ST_FX_LSB +: NUM_PORTS] = fx_w;
        rd[ST_SCR_LSB +: NUM_PORTS] = scr_w;
        rd[ST_FD_LSB +: NUM_PORTS] = fd_w;
      end
      default: begin
        rd = RDATA_RESET;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.cfg0_prev = cfg[0];
    next_st.restart = 1'b0;
    case (st.mode)
      MODE_LOAD: begin
        next_st = apply_pins(next_st, cfg, an_p, dup_all, dup_fx, scr_p);
        next_st.load_cnt = st.load_cnt + 2'h1;
        if (st.load_cnt == LOAD_CYCLES - 2'h1) begin
          next_st.mode = MODE_RUN;
        end
      end
      MODE_RUN: begin
        if (md) begin
          next_st = apply_pins(next_st, cfg, an_p, dup_all, dup_fx, scr_p);
        end else if (wr_ok && (PADDR == ADDR_CONTROL)) begin
          next_st.an_en = PWDATA[BIT_AN_EN];
          next_st.speed = PWDATA[BIT_SPEED];
          next_st.duplex = PWDATA[BIT_DUPLEX];
        end else if (wr_ok && (PADDR == ADDR_CONFIG)) begin
          next_st.link_off = PWDATA[BIT_LINK_OFF];
          next_st.scr_byp = PWDATA[BIT_SCR_BYP];
          next_st.fx = PWDATA[BIT_FX];
          next_st.fx_duplex = PWDATA[BIT_FX_DUPLEX];
        end
      end
      default: begin
        next_st.mode = MODE_LOAD;
        next_st.load_cnt = LOAD_RESET;
      end
    endcase
    if (restart_edge || sw_restart) begin
      next_st.restart = 1'b1;
    end
    if (setup) begin
      next_st.rdata = PWRITE ? RDATA_RESET : rd;
      next_st.slverr = !mapped || (PWRITE && (md || !run || read_only));
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      st <= '0;
    end else if (CE) begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Ports
  // ----------------------------------------------------------------
  generate
    for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
      port_mode u_port (
        .clk(CLK),
        .srst(SRST),
        .ce(CE),
        .restart_req(st.restart),
        .fx_sel(st.fx),
        .scr_pin(st.scr_byp),
        .duplex_all(st.duplex),
        .fx_duplex(st.fx_duplex),
        .restart(AUTONEG_RESTART[i]),
        .fx_mode(fx_w[i]),
        .scr_off(scr_w[i]),
        .full_duplex(fd_w[i])
      );
    end
  endgenerate

  assign FX_MODE = fx_w;
  assign SCRAMBLER_OFF = scr_w;
  assign FULL_DUPLEX = fd_w;
  assign AUTONEG_ON = st.an_en;
  assign SPEED_100 = st.speed;
  assign LINK_TEST_OFF = st.link_off;
  assign ADVERTISE = st.adv;
  assign PRDATA = st.rdata;
  assign PSLVERR = st.slverr;
  assign PREADY = 1'b1;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_restart_edge: assert property (@(posedge CLK) disable iff (SRST)
    (CE && run && st.an_en && cfg[0] && !st.cfg0_prev) |=> st.restart)
    else $error("Restart edge did not set the restart bit.");

  a_restart_clear: assert property (@(posedge CLK) disable iff (SRST)
    (CE && st.restart && !restart_edge && !sw_restart) |=> !st.restart)
    else $error("Restart bit did not clear after one cycle.");

  a_forced_speed: assert property (@(posedge CLK) disable iff (SRST)
    (CE && run && md && !an_p) |=> (SPEED_100 == $past(cfg[0])))
    else $error("Forced speed does not follow config input zero.");

  a_advert_pins: assert property (@(posedge CLK) disable iff (SRST)
    (CE && run && md && an_p) |=>
      (ADVERTISE == advert($past(cfg[1]), $past(cfg[2]), $past(dup_all))))
    else $error("Advertisement does not follow the config inputs.");

  a_link_test: assert property (@(posedge CLK) disable iff (SRST)
    (CE && run && md && !an_p) |=> (LINK_TEST_OFF == $past(cfg[1])))
    else $error("Link test control does not follow config input one.");

  a_media_sel: assert property (@(posedge CLK) disable iff (SRST)
    (CE && run && md && !an_p) |=> (st.fx == $past(cfg[2])))
    else $error("Media select does not follow config input two.");

  a_scr_pin: assert property (@(posedge CLK) disable iff (SRST)
    (CE && run && md) |=> (st.scr_byp == $past(scr_p)))
    else $error("Scrambler bypass bit does not follow its input.");

  a_autoneg_pin: assert property (@(posedge CLK) disable iff (SRST)
    (CE && run && md) |=> (AUTONEG_ON == $past(an_p)))
    else $error("Negotiation enable does not follow its input.");

  a_locked_write: assert property (@(posedge CLK) disable iff (SRST)
    (CE && setup && PWRITE && md) |=> PSLVERR)
    else $error("Write under management disable was not refused.");

  a_load_to_run: assert property (@(posedge CLK) disable iff (SRST)
    (CE && !run && st.load_cnt == LOAD_CYCLES - 2'h1) |=> run)
    else $error("Reset load did not hand over to run mode.");

  a_sw_control: assert property (@(posedge CLK) disable iff (SRST)
    (CE && wr_ok && (PADDR == ADDR_CONTROL)) |=>
      (AUTONEG_ON == $past(PWDATA[BIT_AN_EN]) && SPEED_100 == $past(PWDATA[BIT_SPEED])))
    else $error("Control write under management did not land.");

  a_load_refused: assert property (@(posedge CLK) disable iff (SRST)
    (CE && setup && PWRITE && !run) |=> PSLVERR)
    else $error("Write during the reset load was not refused.");

  a_restart_forced_off: assert property (@(posedge CLK) disable iff (SRST)
    (CE && !st.an_en && !sw_restart) |=> !st.restart)
    else $error("Restart bit set while negotiation was off.");

  a_adv_hold: assert property (@(posedge CLK) disable iff (SRST)
    (CE && run && md && !an_p) |=> (ADVERTISE == $past(ADVERTISE)))
    else $error("Advertisement changed while negotiation was off.");

  c_pin_restart: cover property (@(posedge CLK) disable iff (SRST)
    restart_edge ##2 AUTONEG_RESTART[0]);

  c_fiber_mode: cover property (@(posedge CLK) disable iff (SRST)
    FX_MODE[0] && SCRAMBLER_OFF[0] && FULL_DUPLEX[0]);

  c_sw_write: cover property (@(posedge CLK) disable iff (SRST)
    wr_ok && (PADDR == ADDR_CONTROL));

  c_refused: cover property (@(posedge CLK) disable iff (SRST)
    PSEL && PENABLE && PSLVERR);

endmodule

// [src/hw_cfg_pkg.sv]
package hw_cfg_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_PORTS = 4;
  localparam int PIN_COUNT = 8;
  localparam int ADDR_W = 8;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_ADVERT = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_SPEED = 13;
  localparam int BIT_AN_EN = 12;
  localparam int BIT_RESTART = 9;
  localparam int BIT_DUPLEX = 8;
  localparam int BIT_LINK_OFF = 8;
  localparam int BIT_SCR_BYP = 3;
  localparam int BIT_FX = 2;
  localparam int BIT_FX_DUPLEX = 0;
  localparam int ST_MD = 0;
  localparam int ST_LOADING = 1;
  localparam int ST_FX_LSB = 8;
  localparam int ST_SCR_LSB = 12;
  localparam int ST_FD_LSB = 16;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [1:0] LOAD_RESET = 2'h0;
  localparam logic [1:0] LOAD_CYCLES = 2'h3;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  typedef enum logic [0:0] {
    MODE_LOAD = 1'b0,
    MODE_RUN = 1'b1
  } mode_t;

endpackage

// [src/pin_sync.sv]
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 8
) (
  input logic clk,
  input logic srst,
  input logic ce,
  input logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;

  sync_t st;
  sync_t next_st;

  always_comb begin
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign q = st.s2;

  a_sync_delay: assert property (@(posedge clk) disable iff (srst)
    ((!srst && ce) ##1 ce) |=> (q == $past(d, 2)))
    else $error("Synchronised pin does not follow its input two cycles later.");

endmodule

// [src/port_mode.sv]
`timescale 1ns/10ps
module port_mode (
  input logic clk,
  input logic srst,
  input logic ce,
  input logic restart_req,
  input logic fx_sel,
  input logic scr_pin,
  input logic duplex_all,
  input logic fx_duplex,
  output logic restart,
  output logic fx_mode,
  output logic scr_off,
  output logic full_duplex
);
  typedef struct packed {
    logic restart;
    logic fx_mode;
    logic scr_off;
    logic full_duplex;
  } port_state_t;

  port_state_t st;
  port_state_t next_st;

  always_comb begin
    next_st.restart = restart_req;
    next_st.fx_mode = fx_sel;
    next_st.scr_off = fx_sel | scr_pin;
    next_st.full_duplex = duplex_all | (fx_duplex & fx_sel);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign restart = st.restart;
  assign fx_mode = st.fx_mode;
  assign scr_off = st.scr_off;
  assign full_duplex = st.full_duplex;

  a_fx_scrambler: assert property (@(posedge clk) disable iff (srst)
    fx_mode |-> scr_off)
    else $error("Fiber port runs with its scrambler in use.");

  a_tp_duplex: assert property (@(posedge clk) disable iff (srst)
    (ce && !fx_sel && !duplex_all) |=> !full_duplex)
    else $error("Twisted pair port took the fiber duplex enable.");

  a_all_duplex: assert property (@(posedge clk) disable iff (srst)
    (ce && duplex_all) |=> full_duplex)
    else $error("All port duplex enable did not give full duplex.");

  a_restart_pulse: assert property (@(posedge clk) disable iff (srst)
    (ce && restart_req) |=> restart)
    else $error("Port did not restart negotiation on request.");

endmodule

// [tb/strap_source.sv]
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Board strap source
// ----------------------------------------------------------------
module strap_source (
  input wire logic clk,
  input wire logic [7:0] want,
  output logic [2:0] cfg,
  output logic an,
  output logic md,
  output logic byp,
  output logic fde,
  output logic fdx
);
  // Straps are quiet at time zero; want is {md, an, byp, fde, fdx, cfg}.
  initial begin
    {md, an, byp, fde, fdx, cfg} = 8'h00;
  end

  always @(posedge clk) begin
    {md, an, byp, fde, fdx, cfg[2:1]} <= want[7:1];
    // Forced fiber is only ever strapped together with 100 Mbps.
    cfg[0] <= want[0] | (!want[6] & want[2]);
  end
  // One global media select is strapped, as the per-port select pins lie outside.
endmodule

// [tb/hw_pin_config_control_tb_top.sv]
`timescale 1ns/10ps
module hw_pin_config_control_tb_top;
  import hw_cfg_pkg::*;
  typedef struct packed {
    logic [6:0] pin;
    logic [9:0] exp;
  } row_t;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [7:0] want = 8'h80;
  logic [2:0] cfg;
  logic an, md, byp, fde, fdx;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, an_on, speed, link_off, err;
  logic [3:0] adv, restart, fx, scr, fd;
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;
  int pulses;
  // Rows: pin {an, byp, fde, fdx, cfg}; exp {an_on, speed, link_off, fx, scr, fd, adv}.
  row_t rows [7] = '{{7'h00, 10'h000}, {7'h2a, 10'h0a0}, {7'h0d, 10'h170},
    {7'h11, 10'h110}, {7'h50, 10'h313}, {7'h62, 10'h324}, {7'h54, 10'h31f}};

  always #25 clk = ~clk;

  strap_source straps (.clk(clk), .want(want), .cfg(cfg), .an(an), .md(md), .byp(byp),
    .fde(fde), .fdx(fdx));

  hw_pin_config_control dut (
    .CLK(clk),
    .SRST(srst),
    .CE(ce),
    .CONFIG_IN(cfg),
    .AUTONEG_ENABLE_IN(an),
    .MANAGEMENT_DISABLE_IN(md),
    .SCRAMBLER_BYPASS_IN(byp),
    .ALL_PORT_DUPLEX_ENABLE(fde),
    .FIBER_PORT_DUPLEX_ENABLE(fdx),
    .PSEL(psel),
    .PENABLE(penable),
    .PWRITE(pwrite),
    .PADDR(paddr),
    .PWDATA(pwdata),
    .PRDATA(prdata),
    .PREADY(pready),
    .PSLVERR(pslverr),
    .AUTONEG_ON(an_on),
    .SPEED_100(speed),
    .LINK_TEST_OFF(link_off),
    .ADVERTISE(adv),
    .AUTONEG_RESTART(restart),
    .FX_MODE(fx),
    .SCRAMBLER_OFF(scr),
    .FULL_DUPLEX(fd)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic results;
    $display("Comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic count_pulses;
    pulses = 0;
    repeat (12) begin
      @(posedge clk);
      if (restart === 4'hf) begin
        pulses++;
      end else if (restart !== 4'h0) begin
        pulses += 10;
      end
    end
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    chk("PRDATA", 32'h0, prdata);
    chk("FX_MODE", 32'h0, {28'h0, fx});
    srst <= 1'b0;
    foreach (rows[i]) begin
      @(posedge clk);
      want <= {1'b1, rows[i].pin};
      repeat (8) @(posedge clk);
      chk("AUTONEG_ON", {31'h0, rows[i].exp[9]}, {31'h0, an_on});
      chk("SPEED_100", {31'h0, rows[i].exp[8]}, {31'h0, speed});
      chk("LINK_TEST_OFF", {31'h0, rows[i].exp[7]}, {31'h0, link_off});
      chk("FX_MODE", {28'h0, {4{rows[i].exp[6]}}}, {28'h0, fx});
      chk("SCRAMBLER_OFF", {28'h0, {4{rows[i].exp[5]}}}, {28'h0, scr});
      chk("FULL_DUPLEX", {28'h0, {4{rows[i].exp[4]}}}, {28'h0, fd});
      if (rows[i].pin[6]) begin
        chk("ADVERTISE", {28'h0, rows[i].exp[3:0]}, {28'h0, adv});
      end
    end
    @(posedge clk);
    want <= 8'hd5;
    count_pulses();
    chk("restart pulses", 32'h1, pulses);
    want <= 8'h80;
    repeat (8) @(posedge clk);
    want <= 8'h81;
    count_pulses();
    chk("forced restart pulses", 32'h0, pulses);
    chk("SPEED_100", 32'h1, {31'h0, speed});
    ce <= 1'b0;
    want <= 8'h80;
    repeat (8) @(posedge clk);
    chk("SPEED_100", 32'h1, {31'h0, speed});
    ce <= 1'b1;
    repeat (8) @(posedge clk);
    chk("SPEED_100", 32'h0, {31'h0, speed});
    apb(1'b1, ADDR_CONTROL, 32'h0000_2000, rd, err);
    chk("PSLVERR", 32'h1, {31'h0, err});
    repeat (2) @(posedge clk);
    chk("SPEED_100", 32'h0, {31'h0, speed});
    srst <= 1'b1;
    want <= 8'h0d;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    repeat (8) @(posedge clk);
    chk("FX_MODE", 32'hf, {28'h0, fx});
    chk("FULL_DUPLEX", 32'hf, {28'h0, fd});
    want <= 8'h00;
    repeat (8) @(posedge clk);
    chk("FX_MODE", 32'hf, {28'h0, fx});
    apb(1'b1, ADDR_CONFIG, 32'h0000_0008, rd, err);
    chk("PSLVERR", 32'h0, {31'h0, err});
    repeat (4) @(posedge clk);
    chk("FX_MODE", 32'h0, {28'h0, fx});
    chk("SCRAMBLER_OFF", 32'hf, {28'h0, scr});
    chk("FULL_DUPLEX", 32'h0, {28'h0, fd});
    apb(1'b0, ADDR_CONFIG, 32'h0000_0000, rd, err);
    chk("CONFIG", 32'h0000_0008, rd);
    apb(1'b1, ADDR_CONFIG, 32'h0000_0004, rd, err);
    repeat (4) @(posedge clk);
    chk("SCRAMBLER_OFF", 32'hf, {28'h0, scr});
    apb(1'b0, 8'h40, 32'h0000_0000, rd, err);
    chk("PSLVERR", 32'h1, {31'h0, err});
    apb(1'b1, ADDR_ADVERT, 32'h0000_000f, rd, err);
    chk("PSLVERR", 32'h1, {31'h0, err});
    apb(1'b1, ADDR_CONTROL, 32'h0000_1200, rd, err);
    chk("PREADY", 32'h1, {31'h0, pready});
    count_pulses();
    chk("software restart pulses", 32'h1, pulses);
    chk("AUTONEG_ON", 32'h1, {31'h0, an_on});
    chk("SPEED_100", 32'h0, {31'h0, speed});
    results();
  end
endmodule
